// >>> ocp_pkg.sv
// Constants, register map and field layout of the overcurrent protection timing block.
// Function
// - Definite time operates once current stays above pickup for the set delay.
// - Delay equals multiplier seconds, zero to 600.00 s in 10 ms steps.
// - Timed reset from full accumulator lasts the multiplier value in seconds.
// - Phase time element picks one of four signal sources.
// - Phase time element uses phasor or RMS magnitude per input setting.
// - Pickup setting spans 0 to 30.000 pu in 0.001 pu steps.
// - Time multiplier spans 0.00 to 600.00 in 0.01 steps.
// - Reset method is instantaneous or timed, governing accumulator decay.
// - A block input discharges the accumulator per the reset method.
// - Instantaneous reset plus block clears the accumulator on the next clock edge.
// - Voltage restraint scales pickup by a factor from phase-phase voltage.
// - Without voltage restraint the effective pickup equals the setting.
// - Phase instantaneous element uses phasor magnitude, optional definite delay.
// - Neutral time element uses three times zero sequence, phasor or RMS.
// - Neutral instantaneous quantity is 3|I0| minus three sixteenths of |I1|.
// - Neutral element counts follow fitted modules: 4/4, 6/6 or 6/8.
// - Ground element counts follow the same module-dependent pattern.
// - Custom curve store holds forty-one recloser curves.
package ocp_pkg;
   // ----------------------------------------------------------------
   // Timing.
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int STEP_MS = 10;
   // Cycles per millisecond come first, so the product stays inside a 32-bit int.
   localparam int STEP_CYC = STEP_MS * (1000000000 / CLK_PERIOD_PS);
   // ----------------------------------------------------------------
   // Setting limits.
   // ----------------------------------------------------------------
   localparam logic [15:0] PICKUP_MAX = 16'd30000;
   localparam logic [15:0] MULT_MAX = 16'd60000;
   localparam logic [15:0] PICKUP_RST = 16'd1000;
   localparam logic [15:0] MULT_RST = 16'd100;
   localparam int NUM_ELEM = 4;
   localparam int NUM_CURVE = 41;
   // Restraint factor is in 1/1024 units, floored at about 0.1.
   localparam logic [10:0] MVR_MIN = 11'h066;
   localparam logic [10:0] MVR_ONE = 11'h400;
   // ----------------------------------------------------------------
   // Element indices.
   // ----------------------------------------------------------------
   localparam int E_PH_TIME = 0;
   localparam int E_PH_INST = 1;
   localparam int E_NT_TIME = 2;
   localparam int E_NT_INST = 3;
   // ----------------------------------------------------------------
   // Register map: element e at e*E_STRIDE.
   // ----------------------------------------------------------------
   localparam logic [7:0] E_STRIDE = 8'h10;
   localparam logic [3:0] OFS_CFG = 4'h0;
   localparam logic [3:0] OFS_PICKUP = 4'h4;
   localparam logic [3:0] OFS_MULT = 4'h8;
   localparam logic [3:0] OFS_ACC = 4'hC;
   localparam logic [7:0] ADDR_STATUS = 8'h40;
   localparam logic [7:0] ADDR_COUNT = 8'h44;
   localparam logic [7:0] ADDR_CURVE_IDX = 8'h48;
   localparam logic [7:0] ADDR_CURVE_DAT = 8'h4C;
   // Configuration fields.
   localparam int CFG_EN = 0;
   localparam int CFG_SRC = 1;
   localparam int CFG_RMS = 3;
   localparam int CFG_TIMED = 4;
   localparam int CFG_VR = 5;
   localparam int CFG_W = 6;
   localparam logic [5:0] CFG_RST = 6'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Element counts for fitted module pairs.
   localparam logic [3:0] CNT_SMALL = 4'h4;
   localparam logic [3:0] CNT_MID = 4'h6;
   localparam logic [3:0] CNT_LARGE = 4'h8;
endpackage

// >>> ocp_top.sv
// Overcurrent protection timing: phase and neutral time and instantaneous elements.
`timescale 1ns/10ps
`default_nettype none
module ocp_top #(
   parameter int STEP_CYCLES = ocp_pkg::STEP_CYC
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_en,
   input wire logic [3:0][15:0] src_phase_phasor,
   input wire logic [3:0][15:0] src_phase_rms,
   input wire logic [3:0][15:0] src_zero_phasor,
   input wire logic [3:0][15:0] src_zero_rms,
   input wire logic [3:0][15:0] src_pos_phasor,
   input wire logic [3:0][10:0] src_vpp,
   input wire logic [3:0] block_in,
   input wire logic slot_f_large,
   input wire logic slot_m_large,
   output logic [3:0] pickup_out,
   output logic [3:0] operate_out,
   output logic [3:0] time_elem_count,
   output logic [3:0] inst_elem_count,
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready
);
   // ----------------------------------------------------------------
   // Helpers.
   // ----------------------------------------------------------------
   // Merges byte lanes of a write into an old word.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Clamps a setting to its upper limit.
   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lim);
      return (v > lim) ? lim : v;
   endfunction

   // True for an address that falls in the element register bank.
   function automatic logic is_elem(input logic [7:0] a);
      return a < ocp_pkg::ADDR_STATUS;
   endfunction

   logic [ocp_pkg::CFG_W-1:0] cfg_r [ocp_pkg::NUM_ELEM];
   logic [15:0] pickup_r [ocp_pkg::NUM_ELEM];
   logic [15:0] mult_r [ocp_pkg::NUM_ELEM];
   logic [15:0] acc_r [ocp_pkg::NUM_ELEM];
   logic [15:0] curve_mem [ocp_pkg::NUM_CURVE];
   logic [5:0] curve_idx_r;
   logic [17:0] opq [ocp_pkg::NUM_ELEM];
   logic [15:0] pk_eff [ocp_pkg::NUM_ELEM];
   logic [3:0] over;
   logic [22:0] step_cnt_r;
   logic step_r;

   // ----------------------------------------------------------------
   // Bus slave.
   // ----------------------------------------------------------------
   logic [7:0] waddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_go;
   logic [1:0] e_w;
   logic [1:0] e_r;
   logic [31:0] rd_nxt;
   logic [1:0] rresp_nxt;

   assign wr_go = !s_awready && !s_wready && !s_bvalid;
   assign e_w = waddr_r[5:4];
   assign e_r = s_araddr[5:4];

   // Address and data are caught independently, in either order.
   always_ff @(posedge clock) begin
      if (reset) begin
         s_awready <= 1'b1;
         s_wready <= 1'b1;
         s_bvalid <= 1'b0;
         s_bresp <= ocp_pkg::RESP_OKAY;
         waddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (clock_en) begin
         if (s_awvalid && s_awready) begin
            s_awready <= 1'b0;
            waddr_r <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            s_wready <= 1'b0;
            wdata_r <= s_wdata;
            wstrb_r <= s_wstrb;
         end
         if (wr_go) begin
            s_bvalid <= 1'b1;
            s_bresp <= (waddr_r > ocp_pkg::ADDR_CURVE_DAT || waddr_r[1:0] != 2'h0) ?
                       ocp_pkg::RESP_SLVERR : ocp_pkg::RESP_OKAY;
         end
         if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
            s_awready <= 1'b1;
            s_wready <= 1'b1;
         end
      end
   end

   // Setting writes; out-of-range values are clamped rather than refused.
   always_ff @(posedge clock) begin
      if (reset) begin
         for (int e = 0; e < ocp_pkg::NUM_ELEM; e++) begin
            cfg_r[e] <= ocp_pkg::CFG_RST;
            pickup_r[e] <= ocp_pkg::PICKUP_RST;
            mult_r[e] <= ocp_pkg::MULT_RST;
         end
         curve_idx_r <= 6'h00;
      end else if (clock_en && wr_go && is_elem(waddr_r)) begin
         unique case (waddr_r[3:0])
            ocp_pkg::OFS_CFG: begin
               cfg_r[e_w] <= 6'(merge({26'h0, cfg_r[e_w]}, wdata_r, wstrb_r));
            end
            ocp_pkg::OFS_PICKUP: begin
               pickup_r[e_w] <= clamp(16'(merge({16'h0, pickup_r[e_w]}, wdata_r, wstrb_r)),
                                      ocp_pkg::PICKUP_MAX);
            end
            ocp_pkg::OFS_MULT: begin
               mult_r[e_w] <= clamp(16'(merge({16'h0, mult_r[e_w]}, wdata_r, wstrb_r)),
                                    ocp_pkg::MULT_MAX);
            end
            default: begin
            end
         endcase
      end else if (clock_en && wr_go && waddr_r == ocp_pkg::ADDR_CURVE_IDX && wstrb_r[0]) begin
         curve_idx_r <= wdata_r[5:0];
      end
   end

   // Curve store for user recloser shapes; an index past the last curve is ignored.
   always_ff @(posedge clock) begin
      if (clock_en && wr_go && waddr_r == ocp_pkg::ADDR_CURVE_DAT
          && curve_idx_r < 6'(ocp_pkg::NUM_CURVE)) begin
         curve_mem[curve_idx_r] <= 16'(merge({16'h0, curve_mem[curve_idx_r]}, wdata_r,
                                             wstrb_r));
      end
   end

   // Read decode.
   always_comb begin
      rd_nxt = 32'h0000_0000;
      rresp_nxt = ocp_pkg::RESP_OKAY;
      if (s_araddr[1:0] != 2'h0) begin
         rresp_nxt = ocp_pkg::RESP_SLVERR;
      end else if (is_elem(s_araddr)) begin
         unique case (s_araddr[3:0])
            ocp_pkg::OFS_CFG: rd_nxt = {26'h0, cfg_r[e_r]};
            ocp_pkg::OFS_PICKUP: rd_nxt = {16'h0, pickup_r[e_r]};
            ocp_pkg::OFS_MULT: rd_nxt = {16'h0, mult_r[e_r]};
            default: rd_nxt = {16'h0, acc_r[e_r]};
         endcase
      end else if (s_araddr == ocp_pkg::ADDR_STATUS) begin
         rd_nxt = {24'h0, operate_out, pickup_out};
      end else if (s_araddr == ocp_pkg::ADDR_COUNT) begin
         rd_nxt = {24'h0, inst_elem_count, time_elem_count};
      end else if (s_araddr == ocp_pkg::ADDR_CURVE_IDX) begin
         rd_nxt = {26'h0, curve_idx_r};
      end else if (s_araddr == ocp_pkg::ADDR_CURVE_DAT) begin
         rd_nxt = (curve_idx_r < 6'(ocp_pkg::NUM_CURVE)) ? {16'h0, curve_mem[curve_idx_r]}
                                                        : 32'h0000_0000;
      end else begin
         rresp_nxt = ocp_pkg::RESP_SLVERR;
      end
   end

   // Read channel answers one cycle after the address is taken.
   always_ff @(posedge clock) begin
      if (reset) begin
         s_arready <= 1'b1;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= ocp_pkg::RESP_OKAY;
      end else if (clock_en) begin
         if (s_arvalid && s_arready) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b1;
            s_rdata <= rd_nxt;
            s_rresp <= rresp_nxt;
         end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
            s_arready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Evaluation step of 10 ms: one accumulator count per step.
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         step_cnt_r <= 23'h000000;
         step_r <= 1'b0;
      end else if (clock_en) begin
         step_r <= (step_cnt_r == 23'(STEP_CYCLES - 1));
         step_cnt_r <= (step_cnt_r == 23'(STEP_CYCLES - 1)) ? 23'h000000
                                                            : step_cnt_r + 23'h000001;
      end
   end

   // ----------------------------------------------------------------
   // Operating quantities.
   // ----------------------------------------------------------------
   logic [1:0] sel [ocp_pkg::NUM_ELEM];
   logic [17:0] zero3_nt;
   logic [17:0] zero3_ni;
   logic [17:0] pos3_ni;
   logic [26:0] pk_scaled;
   logic [10:0] mvr;

   always_comb begin
      for (int e = 0; e < ocp_pkg::NUM_ELEM; e++) begin
         sel[e] = cfg_r[e][ocp_pkg::CFG_SRC +: 2];
      end
      opq[ocp_pkg::E_PH_TIME] = {2'h0, cfg_r[0][ocp_pkg::CFG_RMS] ?
                                 src_phase_rms[sel[0]] : src_phase_phasor[sel[0]]};
      opq[ocp_pkg::E_PH_INST] = {2'h0, src_phase_phasor[sel[1]]};
      zero3_nt = 18'(3) * {2'h0, cfg_r[2][ocp_pkg::CFG_RMS] ?
                            src_zero_rms[sel[2]] : src_zero_phasor[sel[2]]};
      opq[ocp_pkg::E_NT_TIME] = zero3_nt;
      // Positive-sequence restraint, floored at zero so a balanced load never operates.
      zero3_ni = 18'(3) * {2'h0, src_zero_phasor[sel[3]]};
      pos3_ni = (18'(3) * {2'h0, src_pos_phasor[sel[3]]}) >> 4;
      opq[ocp_pkg::E_NT_INST] = (zero3_ni > pos3_ni) ? zero3_ni - pos3_ni : 18'h00000;
   end

   // Effective pickup; only the phase time element has voltage restraint.
   always_comb begin
      mvr = src_vpp[sel[0]];
      if (mvr < ocp_pkg::MVR_MIN) begin
         mvr = ocp_pkg::MVR_MIN;
      end else if (mvr > ocp_pkg::MVR_ONE) begin
         mvr = ocp_pkg::MVR_ONE;
      end
      pk_scaled = 27'(pickup_r[0]) * 27'(mvr);
      for (int e = 0; e < ocp_pkg::NUM_ELEM; e++) begin
         pk_eff[e] = pickup_r[e];
      end
      if (cfg_r[0][ocp_pkg::CFG_VR]) begin
         pk_eff[0] = pk_scaled[25:10];
      end
      for (int e = 0; e < ocp_pkg::NUM_ELEM; e++) begin
         over[e] = opq[e] > {2'h0, pk_eff[e]};
      end
   end

   // ----------------------------------------------------------------
   // Element timers.
   // ----------------------------------------------------------------
   // Timed reset walks the accumulator down one step per 10 ms, so a full
   // accumulator takes the multiplier value in seconds to drain.
   always_ff @(posedge clock) begin
      if (reset) begin
         for (int e = 0; e < ocp_pkg::NUM_ELEM; e++) begin
            acc_r[e] <= 16'h0000;
         end
         pickup_out <= 4'h0;
         operate_out <= 4'h0;
      end else if (clock_en) begin
         for (int e = 0; e < ocp_pkg::NUM_ELEM; e++) begin
            pickup_out[e] <= cfg_r[e][ocp_pkg::CFG_EN] && !block_in[e] && over[e];
            operate_out[e] <= cfg_r[e][ocp_pkg::CFG_EN] && !block_in[e] && over[e]
                              && acc_r[e] >= mult_r[e];
            if (!cfg_r[e][ocp_pkg::CFG_EN]) begin
               acc_r[e] <= 16'h0000;
            end else if (block_in[e] || !over[e]) begin
               if (!cfg_r[e][ocp_pkg::CFG_TIMED]) begin
                  acc_r[e] <= 16'h0000;
               end else if (step_r && acc_r[e] != 16'h0000) begin
                  acc_r[e] <= acc_r[e] - 16'h0001;
               end
            end else if (step_r && acc_r[e] < mult_r[e]) begin
               acc_r[e] <= acc_r[e] + 16'h0001;
            end
         end
      end
   end

   // Element counts from the fitted module pair, reported for neutral and ground.
   always_ff @(posedge clock) begin
      if (reset) begin
         time_elem_count <= ocp_pkg::CNT_SMALL;
         inst_elem_count <= ocp_pkg::CNT_SMALL;
      end else if (clock_en) begin
         time_elem_count <= (slot_f_large || slot_m_large) ? ocp_pkg::CNT_MID
                                                           : ocp_pkg::CNT_SMALL;
         inst_elem_count <= (slot_f_large && slot_m_large) ? ocp_pkg::CNT_LARGE :
                            (slot_f_large || slot_m_large) ? ocp_pkg::CNT_MID
                                                           : ocp_pkg::CNT_SMALL;
      end
   end

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   sequence aw_w_taken_s;
      clock_en && wr_go;
   endsequence

   disabled_quiet_a: assert property (@(posedge clock) disable iff (reset)
      clock_en && !cfg_r[0][ocp_pkg::CFG_EN] |=> !operate_out[0] && acc_r[0] == 16'h0000)
      else $error("Disabled element not quiet.");

   inst_clear_a: assert property (@(posedge clock) disable iff (reset)
      clock_en && cfg_r[1][ocp_pkg::CFG_EN] && !cfg_r[1][ocp_pkg::CFG_TIMED] && block_in[1]
      |=> acc_r[1] == 16'h0000)
      else $error("Blocked accumulator not cleared.");

   timed_decay_a: assert property (@(posedge clock) disable iff (reset)
      clock_en && cfg_r[2][ocp_pkg::CFG_EN] && cfg_r[2][ocp_pkg::CFG_TIMED] && !over[2]
      && step_r && acc_r[2] != 16'h0000 |=> acc_r[2] == $past(acc_r[2]) - 16'h0001)
      else $error("Timed reset did not decay by one.");

   operate_cause_a: assert property (@(posedge clock) disable iff (reset)
      $rose(operate_out[0]) |-> $past(over[0]) && $past(acc_r[0]) >= $past(mult_r[0]))
      else $error("Operate without elapsed time.");

   restraint_off_a: assert property (@(posedge clock) disable iff (reset)
      !cfg_r[0][ocp_pkg::CFG_VR] |-> pk_eff[0] == pickup_r[0])
      else $error("Pickup changed without restraint.");

   neutral_opq_a: assert property (@(posedge clock) disable iff (reset)
      src_pos_phasor[sel[3]] == 16'h0000 |-> opq[3] == 18'(3) * {2'h0, src_zero_phasor[sel[3]]})
      else $error("Neutral quantity wrong.");

   setting_limit_a: assert property (@(posedge clock) disable iff (reset)
      pickup_r[0] <= ocp_pkg::PICKUP_MAX && mult_r[0] <= ocp_pkg::MULT_MAX)
      else $error("Setting above limit.");

   // The response must follow the internal write by exactly one edge.
   write_resp_a: assert property (@(posedge clock) disable iff (reset)
      aw_w_taken_s |=> s_bvalid)
      else $error("Write response missing.");

   // Between step pulses a running accumulator must not move at all.
   acc_step_a: assert property (@(posedge clock) disable iff (reset)
      clock_en && cfg_r[0][ocp_pkg::CFG_EN] && !block_in[0] && over[0] && !step_r
      |=> $stable(acc_r[0]))
      else $error("Accumulator moved between steps.");

   // A zero delay means the instantaneous element operates one edge after its current exceeds pickup.
   inst_operate_a: assert property (@(posedge clock) disable iff (reset)
      clock_en && cfg_r[1][ocp_pkg::CFG_EN] && !block_in[1] && over[1]
      && mult_r[1] == 16'h0000 |=> operate_out[1])
      else $error("Undelayed instantaneous element did not operate.");

   count_map_a: assert property (@(posedge clock) disable iff (reset)
      clock_en && slot_f_large && slot_m_large |=> inst_elem_count == ocp_pkg::CNT_LARGE
      && time_elem_count == ocp_pkg::CNT_MID)
      else $error("Element count mismatch.");
endmodule
`default_nettype wire

// >>> ocp_meas_model.sv
// Behavioural model of the upstream current and voltage magnitude stage.
`timescale 1ns/10ps
`default_nettype none
module ocp_meas_model (
   input wire logic clock,
   input wire logic [1:0] sel,
   input wire logic [4:0][15:0] mag,
   input wire logic [10:0] vpp,
   output logic [3:0][15:0] ph_ph,
   output logic [3:0][15:0] ph_rm,
   output logic [3:0][15:0] z_ph,
   output logic [3:0][15:0] z_rm,
   output logic [3:0][15:0] p_ph,
   output logic [3:0][10:0] v_pp
);
   // ----------------------------------------------------------------
   // Sampled magnitudes.
   // ----------------------------------------------------------------
   // New magnitudes land one edge late, as from a real acquisition stage.
   // Unselected phase and zero-sequence sources carry a tiny current, so a wrong source never picks up.
   always_ff @(posedge clock) begin
      for (int s = 0; s < 4; s++) begin
         ph_ph[s] <= (2'(s) == sel) ? mag[0] : 16'h0005;
         ph_rm[s] <= (2'(s) == sel) ? mag[1] : 16'h0005;
         z_ph[s] <= (2'(s) == sel) ? mag[2] : 16'h0001;
         z_rm[s] <= (2'(s) == sel) ? mag[3] : 16'h0001;
         p_ph[s] <= (2'(s) == sel) ? mag[4] : 16'h0000;
         v_pp[s] <= (2'(s) == sel) ? vpp : 11'h400;
      end
   end
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking testbench of the overcurrent protection timing block.
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int S = 8;
   logic clock = 0, reset = 1, sf = 0, sm = 0;
   logic [1:0] sel = 0;
   logic [4:0][15:0] mag = '0;
   logic [10:0] vpp = 11'h400;
   logic [3:0] blk = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   // Response channels stay ready, so no task re-raises a ready it has just dropped.
   logic awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
   logic [31:0] wdata = 0, v;
   logic [1:0] r;
   logic [3:0][15:0] a0, a1, a2, a3, a4;
   logic [3:0][10:0] a5;
   logic [3:0] pk, op, tc, ic;
   logic awrdy, wrdy, bvalid, arrdy, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int n_mismatch = 0, comparisons = 0, c;
   always #2 clock = ~clock;
   ocp_meas_model u_meas (.clock(clock), .sel(sel), .mag(mag), .vpp(vpp), .ph_ph(a0),
      .ph_rm(a1), .z_ph(a2), .z_rm(a3), .p_ph(a4), .v_pp(a5));
   ocp_top #(.STEP_CYCLES(S)) DUT (.clock(clock), .reset(reset), .clock_en(1'b1),
      .src_phase_phasor(a0), .src_phase_rms(a1), .src_zero_phasor(a2), .src_zero_rms(a3),
      .src_pos_phasor(a4), .src_vpp(a5), .block_in(blk), .slot_f_large(sf),
      .slot_m_large(sm), .pickup_out(pk), .operate_out(op), .time_elem_count(tc),
      .inst_elem_count(ic), .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awrdy),
      .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wrdy),
      .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
      .s_arvalid(arvalid), .s_arready(arrdy), .s_rdata(rdata), .s_rresp(rresp),
      .s_rvalid(rvalid), .s_rready(rready));
   // ----------------------------------------------------------------
   // Checking and closing.
   // ----------------------------------------------------------------
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chkr(input logic [1:0] got, input logic [1:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: response %h, expected %h", $time, got, exp);
      end
   endtask
   // Every handshake and operate wait counts edges so a dead handshake ends the run instead of hanging.
   task automatic edge_wait(inout int n);
      @(posedge clock);
      n++;
      if (n > 2000) begin
         n_mismatch++;
         $display("Error at %0t: wait ran out", $time);
         test_done();
      end
   endtask
   // ----------------------------------------------------------------
   // Register bus master.
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ta, tw;
      n = 0;
      ta = 0;
      tw = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      while (!(ta && tw)) begin
         edge_wait(n);
         if (!ta && awrdy === 1'b1) begin
            ta = 1;
            awvalid <= 0;
         end
         if (!tw && wrdy === 1'b1) begin
            tw = 1;
            wvalid <= 0;
         end
      end
      do edge_wait(n); while (bvalid !== 1'b1);
      chkr(bresp, ocp_pkg::RESP_OKAY);
   endtask
   task automatic rx(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1;
      do edge_wait(n); while (arrdy !== 1'b1);
      arvalid <= 0;
      do edge_wait(n); while (rvalid !== 1'b1);
      d = rdata;
      rs = rresp;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] rs;
      rx(a, d, rs);
      chkr(rs, ocp_pkg::RESP_OKAY);
      chk(d, exp);
   endtask
   task automatic wop(input int i);
      c = 0;
      do edge_wait(c); while (op[i] !== 1'b1);
   endtask
   // ----------------------------------------------------------------
   // Test sequence.
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clock);
      reset <= 0;
      @(posedge clock);
      rd(8'h04, 32'(ocp_pkg::PICKUP_RST));
      rd(8'h08, 32'(ocp_pkg::MULT_RST));
      rd(8'h00, 32'h0);
      for (int i = 0; i < 4; i++) begin
         sf <= i[1];
         sm <= i[0];
         repeat (3) @(posedge clock);
         v = (i == 3) ? 32'h86 : ((i == 0) ? 32'h44 : 32'h66);
         rd(ocp_pkg::ADDR_COUNT, v);
         chk({24'h0, ic, tc}, v);
      end
      wr(8'h04, 32'd40000);
      rd(8'h04, 32'd30000);
      wr(8'h08, 32'd65000);
      rd(8'h08, 32'd60000);
      rx(8'h50, v, r);
      chkr(r, ocp_pkg::RESP_SLVERR);
      // The last curve slot keeps its word; an index past it is ignored and reads 0.
      wr(ocp_pkg::ADDR_CURVE_IDX, 32'd40);
      wr(ocp_pkg::ADDR_CURVE_DAT, 32'h0000_ABCD);
      rd(ocp_pkg::ADDR_CURVE_DAT, 32'h0000_ABCD);
      wr(ocp_pkg::ADDR_CURVE_IDX, 32'd41);
      wr(ocp_pkg::ADDR_CURVE_DAT, 32'h0000_1234);
      rd(ocp_pkg::ADDR_CURVE_IDX, 32'd41);
      rd(ocp_pkg::ADDR_CURVE_DAT, 32'h0000_0000);
      $display("test settings done");
      // Definite time on source 2, timed reset, then a block.
      sel <= 2;
      mag[0] <= 16'd1500;
      wr(8'h04, 32'd1000);
      wr(8'h08, 32'd3);
      wr(8'h00, 32'h15);
      wop(0);
      chk(32'(c >= 2 * S - 1 && c <= 3 * S + 3), 1);
      rd(8'h0C, 32'd3);
      blk[0] <= 1;
      repeat (2) @(posedge clock);
      chk(pk[0], 0);
      rx(8'h0C, v, r);
      chk(32'(v >= 2), 1);
      repeat (3 * S + 2) @(posedge clock);
      rd(8'h0C, 32'd0);
      blk[0] <= 0;
      $display("test timed reset done");
      // Instantaneous reset: current loss and block both clear at once.
      wr(8'h00, 32'h05);
      wop(0);
      mag[0] <= 16'd0;
      repeat (3) @(posedge clock);
      rd(8'h0C, 32'd0);
      mag[0] <= 16'd1500;
      wop(0);
      blk[0] <= 1;
      repeat (2) @(posedge clock);
      chk(op[0], 0);
      rd(8'h0C, 32'd0);
      blk[0] <= 0;
      wr(8'h00, 32'h03);
      repeat (4) @(posedge clock);
      chk(pk[0], 0);
      mag[0] <= 16'd0;
      mag[1] <= 16'd1500;
      wr(8'h00, 32'h0D);
      repeat (4) @(posedge clock);
      chk(pk[0], 1);
      mag[0] <= 16'd700;
      vpp <= 11'h200;
      wr(8'h00, 32'h05);
      repeat (4) @(posedge clock);
      chk(pk[0], 0);
      wr(8'h00, 32'h25);
      repeat (4) @(posedge clock);
      chk(pk[0], 1);
      $display("test phase time done");
      // Phase instantaneous ignores the input-type bit.
      mag[0] <= 16'd0;
      wr(8'h18, 32'd0);
      wr(8'h10, 32'h0D);
      repeat (4) @(posedge clock);
      chk(pk[1], 0);
      mag[0] <= 16'd1500;
      repeat (4) @(posedge clock);
      chk(op[1], 1);
      // Neutral elements: 3|I0| = 1200, restraint 3*3200/16 = 600.
      // The neutral time element runs with timed reset, so its decay is exercised.
      mag[2] <= 16'd400;
      mag[4] <= 16'd3200;
      wr(8'h20, 32'h15);
      wr(8'h34, 32'd599);
      wr(8'h30, 32'h05);
      repeat (4) @(posedge clock);
      chk(pk[2], 1);
      chk(pk[3], 1);
      wr(8'h34, 32'd600);
      repeat (4) @(posedge clock);
      chk(pk[3], 0);
      wr(8'h20, 32'h1D);
      repeat (4) @(posedge clock);
      chk(pk[2], 0);
      wr(8'h34, 32'd100);
      wr(8'h30, 32'h00);
      repeat (4 * S) @(posedge clock);
      chk(pk[3], 0);
      rd(8'h3C, 32'd0);
      // Phase time and phase instantaneous elements both operate by now.
      rd(ocp_pkg::ADDR_STATUS, 32'h0000_0033);
      $display("test neutral done");
      test_done();
   end
endmodule
`default_nettype wire
